// ===== src/dqc_pkg.sv
package dqc_pkg;

    localparam int NUM_CHAN = 4;
    localparam int NUM_PIN_SET = 2;
    localparam int ADDR_W = 8;

    // Register byte offsets; each per-channel bank holds one word per channel.
    localparam logic [7:0] CFG_BASE = 8'h00;
    localparam logic [7:0] CTRL_BASE = 8'h10;
    localparam logic [7:0] STATE_BASE = 8'h20;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h30;
    localparam logic [7:0] IRQ_EN_OFS = 8'h34;
    localparam logic [7:0] BANK_MASK = 8'hF0;

    // Channel configuration field positions.
    localparam int BIT_REQ_SIDE = 3;
    localparam int BIT_LOW_EDGE = 4;
    localparam int BIT_HIGH_SIDE = 5;
    localparam int BIT_LEVEL_SENSE = 6;
    localparam int BIT_ACK_MODE_LO = 8;
    localparam int BIT_INVALID_POLICY = 11;
    localparam int BIT_NEXT_SET = 22;
    localparam int BIT_DONE_MASK = 24;
    localparam int BIT_TC_MASK = 25;
    localparam int BIT_DESCR_MASK = 26;
    localparam int BIT_SET_TOGGLE = 29;

    // Channel control and channel state field positions.
    localparam int BIT_SOFT_CLEAR = 0;
    localparam int BIT_ST_DESCR_ERR = 0;
    localparam int BIT_ST_REQ = 1;
    localparam int BIT_ST_ACK = 2;

    // Interrupt status layout: completion events low, descriptor errors above.
    localparam int IRQ_DONE_LO = 0;
    localparam int IRQ_ERR_LO = 4;

    // Reset values.
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    localparam logic [7:0] IRQ_EN_RESET = 8'h00;

    // Acknowledge output modes.
    localparam logic [2:0] ACK_PULSE = 3'h0;
    localparam logic [2:0] ACK_LEVEL = 3'h1;

endpackage

// ===== src/dqc_chan_if.sv
`timescale 1ns/1ps
`default_nettype none

interface dqc_chan_if;
    logic level_sense_sel;
    logic low_edge_enable;
    logic high_side_enable;
    logic [2:0] ack_output_mode;
    logic pin_trig;
    logic req_raw;
    logic bus_cycle;
    logic req_det;
    logic ack;

    modport ctrl (output level_sense_sel, low_edge_enable, high_side_enable, ack_output_mode, pin_trig,
                  req_raw, bus_cycle, input req_det, ack);
    modport chan (input level_sense_sel, low_edge_enable, high_side_enable, ack_output_mode, pin_trig,
                  req_raw, bus_cycle, output req_det, ack);
endinterface

`default_nettype wire

// ===== src/dqc_chan_detect.sv
`timescale 1ns/1ps
`default_nettype none

module dqc_chan_detect
    import dqc_pkg::*;
(
    // Clock and reset.
    input wire logic mclk_in,
    input wire logic rstn_in,
    // Channel link.
    dqc_chan_if.chan ch
);

    logic req_prev_q, req_prev_d;
    logic cyc_prev_q, cyc_prev_d;
    logic det_q, det_d;
    logic ack_q, ack_d;

    always_comb begin
        logic rise;
        logic fall;
        logic cyc_start;
        rise = ch.req_raw & ~req_prev_q;
        fall = ~ch.req_raw & req_prev_q;
        cyc_start = ch.bus_cycle & ~cyc_prev_q;
        req_prev_d = ch.req_raw;
        cyc_prev_d = ch.bus_cycle;
        if (ch.level_sense_sel) begin
            det_d = (ch.high_side_enable & ch.req_raw) | (ch.low_edge_enable & ~ch.req_raw);
        end else begin
            det_d = (ch.high_side_enable & rise) | (ch.low_edge_enable & fall);
        end
        // Interrupt-style triggers never drive the acknowledge pin.
        if (!ch.pin_trig || ch.ack_output_mode[2]) begin
            ack_d = 1'b0;
        end else if (ch.ack_output_mode[1]) begin
            ack_d = ch.bus_cycle;
        end else if (ch.ack_output_mode == ACK_LEVEL) begin
            ack_d = cyc_start | (ack_q & ch.req_raw);
        end else begin
            ack_d = cyc_start;
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            req_prev_q <= 1'b0;
            cyc_prev_q <= 1'b0;
            det_q <= 1'b0;
            ack_q <= 1'b0;
        end else begin
            req_prev_q <= req_prev_d;
            cyc_prev_q <= cyc_prev_d;
            det_q <= det_d;
            ack_q <= ack_d;
        end
    end

    assign ch.req_det = det_q;
    assign ch.ack = ack_q;

endmodule // dqc_chan_detect

`default_nettype wire

// ===== src/dqc_dma_req_ack.sv
`timescale 1ns/1ps
`default_nettype none

module dqc_dma_req_ack
    import dqc_pkg::*;
(
    // Clock and reset.
    input wire logic mclk_in,
    input wire logic rstn_in,
    // Avalon-MM slave.
    input wire logic [ADDR_W-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // External pins, active low.
    input wire logic [NUM_PIN_SET-1:0] xfer_request_n_in,
    output logic [NUM_PIN_SET-1:0] xfer_ack_n_out,
    output logic [NUM_PIN_SET-1:0] terminal_count_n_out,
    output logic realtime_ack_n_out,
    // Trigger side, same clock.
    input wire logic [NUM_CHAN-1:0] periph_req_in,
    input wire logic [NUM_CHAN-1:0] pin_trig_sel_in,
    // Transfer engine side, same clock.
    input wire logic [NUM_CHAN-1:0] bus_cycle_in,
    input wire logic [NUM_CHAN-1:0] xact_done_in,
    input wire logic [NUM_CHAN-1:0] descr_fetch_in,
    input wire logic [NUM_CHAN-1:0] link_valid_flag_in,
    output logic [NUM_CHAN-1:0] xfer_req_out,
    output logic [NUM_CHAN-1:0] req_from_dest_out,
    output logic [NUM_CHAN-1:0] next_set_pick_out,
    output logic [NUM_CHAN-1:0] chan_halt_out,
    // Interrupts.
    output logic [NUM_CHAN-1:0] xfer_done_irq_out,
    output logic [NUM_CHAN-1:0] descr_error_irq_out,
    output logic irq_out
);

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode helpers.

    function automatic logic bank_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] base);
        bank_hit = ((addr & BANK_MASK) == base) && (addr[1:0] == 2'h0);
    endfunction

    function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] wd,
                                                input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        merge_bytes = res;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Pin request synchronisers: three stages, a change counts once stages two and three agree.

    logic [NUM_PIN_SET-1:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_filt_q;
    logic [NUM_PIN_SET-1:0] pin_s1_d, pin_s2_d, pin_s3_d, pin_filt_d;

    always_comb begin
        pin_s1_d = ~xfer_request_n_in;
        pin_s2_d = pin_s1_q;
        pin_s3_d = pin_s2_q;
        // A glitch shorter than two clocks never reaches the filtered value.
        pin_filt_d = pin_filt_q;
        for (int p = 0; p < NUM_PIN_SET; p++) begin
            if (pin_s2_q[p] == pin_s3_q[p]) begin
                pin_filt_d[p] = pin_s3_q[p];
            end
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
            pin_s3_q <= '0;
            pin_filt_q <= '0;
        end else begin
            pin_s1_q <= pin_s1_d;
            pin_s2_q <= pin_s2_d;
            pin_s3_q <= pin_s3_d;
            pin_filt_q <= pin_filt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bus slave: one wait cycle per access, then the access completes.

    logic bus_ack_q, bus_ack_d;
    logic [31:0] rdata_q, rdata_d;
    logic wr_go;
    logic [31:0] cfg_q [NUM_CHAN];
    logic [31:0] cfg_d [NUM_CHAN];
    logic [NUM_CHAN-1:0] derr_q, derr_d;
    logic [7:0] istat_q, istat_d;
    logic [7:0] ien_q, ien_d;
    logic [NUM_CHAN-1:0] det_w, ack_w;
    logic [1:0] ch_idx;

    assign ch_idx = avs_address_in[3:2];
    assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~bus_ack_q;
    assign wr_go = avs_write_in & bus_ack_q;
    assign avs_readdata_out = rdata_q;
    // A request still held after its completing edge counts as a new access.
    // The master must therefore drop read or write at that edge.
    // Read data stay in place until the next read.

    always_comb begin
        // The answer flop alternates while a request stands, giving one wait cycle per access.
        bus_ack_d = (avs_read_in | avs_write_in) & ~bus_ack_q;
        rdata_d = rdata_q;
        if (bus_ack_d && avs_read_in) begin
            rdata_d = 32'h0000_0000;
            if (bank_hit(avs_address_in, CFG_BASE)) begin
                rdata_d = cfg_q[ch_idx];
            end else if (bank_hit(avs_address_in, STATE_BASE)) begin
                rdata_d[BIT_ST_DESCR_ERR] = derr_q[ch_idx];
                rdata_d[BIT_ST_REQ] = det_w[ch_idx];
                rdata_d[BIT_ST_ACK] = ack_w[ch_idx];
            end else if (avs_address_in == IRQ_STAT_OFS) begin
                rdata_d[7:0] = istat_q;
            end else if (avs_address_in == IRQ_EN_OFS) begin
                rdata_d[7:0] = ien_q;
            end
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bus_ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            bus_ack_q <= bus_ack_d;
            rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Channel configuration, descriptor error state and event outputs.

    logic [NUM_CHAN-1:0] done_irq_q, done_irq_d;
    logic [NUM_CHAN-1:0] err_irq_q, err_irq_d;
    logic [NUM_PIN_SET-1:0] tc_q, tc_d;
    logic [NUM_CHAN-1:0] bad_descr;

    assign bad_descr = descr_fetch_in & ~link_valid_flag_in;

    always_comb begin
        for (int n = 0; n < NUM_CHAN; n++) begin
            cfg_d[n] = cfg_q[n];
            // Byte lanes let software change one field group without a read-modify-write.
            if (wr_go && bank_hit(avs_address_in, CFG_BASE) && ch_idx == n[1:0]) begin
                cfg_d[n] = merge_bytes(cfg_q[n], avs_writedata_in, avs_byteenable_in);
            end
            // Register-set swap after completion only when enabled.
            if (xact_done_in[n] && cfg_q[n][BIT_SET_TOGGLE]) begin
                cfg_d[n][BIT_NEXT_SET] = ~cfg_d[n][BIT_NEXT_SET];
            end
            // Soft clear releases a channel halted by a bad descriptor.
            derr_d[n] = derr_q[n];
            if (wr_go && bank_hit(avs_address_in, CTRL_BASE) && ch_idx == n[1:0] && avs_byteenable_in[0]
                && avs_writedata_in[BIT_SOFT_CLEAR]) begin
                derr_d[n] = 1'b0;
            end
            // A new error in the clearing cycle wins.
            if (bad_descr[n] && !cfg_q[n][BIT_INVALID_POLICY]) begin
                derr_d[n] = 1'b1;
            end
            // Completion and error pulses last one cycle and reach the sticky status bits a cycle later.
            done_irq_d[n] = xact_done_in[n] & ~cfg_q[n][BIT_DONE_MASK];
            err_irq_d[n] = bad_descr[n] & ~cfg_q[n][BIT_DESCR_MASK];
        end
        // Only channels with a pin set drive a terminal count pin.
        for (int p = 0; p < NUM_PIN_SET; p++) begin
            tc_d[p] = xact_done_in[p] & ~cfg_q[p][BIT_TC_MASK];
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            for (int n = 0; n < NUM_CHAN; n++) begin
                cfg_q[n] <= CFG_RESET;
            end
            derr_q <= '0;
            done_irq_q <= '0;
            err_irq_q <= '0;
            tc_q <= '0;
        end else begin
            for (int n = 0; n < NUM_CHAN; n++) begin
                cfg_q[n] <= cfg_d[n];
            end
            derr_q <= derr_d;
            done_irq_q <= done_irq_d;
            err_irq_q <= err_irq_d;
            tc_q <= tc_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt status, enable and summary output.

    always_comb begin
        istat_d = istat_q;
        ien_d = ien_q;
        if (wr_go && avs_address_in == IRQ_STAT_OFS && avs_byteenable_in[0]) begin
            istat_d = istat_q & ~avs_writedata_in[7:0];
        end
        if (wr_go && avs_address_in == IRQ_EN_OFS && avs_byteenable_in[0]) begin
            ien_d = avs_writedata_in[7:0];
        end
        // Events are merged after the clear, so an event arriving with a clear write survives.
        // Software that clears a bit in that cycle therefore still sees the new event.
        istat_d[IRQ_DONE_LO +: NUM_CHAN] = istat_d[IRQ_DONE_LO +: NUM_CHAN] | done_irq_q;
        istat_d[IRQ_ERR_LO +: NUM_CHAN] = istat_d[IRQ_ERR_LO +: NUM_CHAN] | err_irq_q;
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            istat_q <= 8'h00;
            ien_q <= IRQ_EN_RESET;
        end else begin
            istat_q <= istat_d;
            ien_q <= ien_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Per-channel request detection and acknowledge generation.

    genvar g;
    generate
        for (g = 0; g < NUM_CHAN; g++) begin : g_chan
            dqc_chan_if chif ();
            assign chif.level_sense_sel = cfg_q[g][BIT_LEVEL_SENSE];
            assign chif.low_edge_enable = cfg_q[g][BIT_LOW_EDGE];
            assign chif.high_side_enable = cfg_q[g][BIT_HIGH_SIDE];
            assign chif.ack_output_mode = cfg_q[g][BIT_ACK_MODE_LO +: 3];
            assign chif.bus_cycle = bus_cycle_in[g];
            // Channels without a pin set never drive an acknowledge pin.
            if (g < NUM_PIN_SET) begin : g_pin
                assign chif.pin_trig = pin_trig_sel_in[g];
                assign chif.req_raw = pin_trig_sel_in[g] ? pin_filt_q[g] : periph_req_in[g];
            end else begin : g_nopin
                assign chif.pin_trig = 1'b0;
                assign chif.req_raw = periph_req_in[g];
            end
            assign det_w[g] = chif.req_det;
            assign ack_w[g] = chif.ack;
            dqc_chan_detect u_det (
                .mclk_in(mclk_in),
                .rstn_in(rstn_in),
                .ch(chif.chan)
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs.

    always_comb begin
        for (int n = 0; n < NUM_CHAN; n++) begin
            req_from_dest_out[n] = cfg_q[n][BIT_REQ_SIDE];
            next_set_pick_out[n] = cfg_q[n][BIT_NEXT_SET];
        end
    end

    // A halted channel passes no further requests to the transfer engine.
    assign xfer_req_out = det_w & ~chan_halt_out;
    assign chan_halt_out = derr_q;
    assign xfer_ack_n_out = ~ack_w[NUM_PIN_SET-1:0];
    assign terminal_count_n_out = ~tc_q;
    // The real-time channel lies outside this block.
    // Its acknowledge pin is held inactive so that an attached device never sees a false answer.
    assign realtime_ack_n_out = 1'b1;
    assign xfer_done_irq_out = done_irq_q;
    assign descr_error_irq_out = err_irq_q;
    assign irq_out = |(istat_q & ien_q);

endmodule // dqc_dma_req_ack

`default_nettype wire

// ===== bench/dqc_dma_req_ack_props.sv
`timescale 1ns/1ps
`default_nettype none

module dqc_dma_req_ack_props
    import dqc_pkg::*;
(
    // Clock and reset.
    input wire logic mclk_in,
    input wire logic rstn_in,
    // Register bus.
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic avs_waitrequest_out,
    // Pins and channel events.
    input wire logic [NUM_PIN_SET-1:0] xfer_ack_n_out,
    input wire logic [NUM_PIN_SET-1:0] terminal_count_n_out,
    input wire logic realtime_ack_n_out,
    input wire logic [NUM_CHAN-1:0] pin_trig_sel_in,
    input wire logic [NUM_CHAN-1:0] xact_done_in,
    input wire logic [NUM_CHAN-1:0] descr_fetch_in,
    input wire logic [NUM_CHAN-1:0] link_valid_flag_in,
    input wire logic [NUM_CHAN-1:0] chan_halt_out,
    input wire logic [NUM_CHAN-1:0] xfer_done_irq_out,
    input wire logic [NUM_CHAN-1:0] descr_error_irq_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);

    a_rt_ack_idle: assert property (realtime_ack_n_out)
        else $error("realtime acknowledge driven active");
    a_bus_answer_time: assert property (
        $rose(avs_read_in || avs_write_in) |-> avs_waitrequest_out ##1 !avs_waitrequest_out)
        else $error("register access not answered on the second edge");
    a_done_irq_cause: assert property ((xfer_done_irq_out & ~$past(xact_done_in)) == 4'h0)
        else $error("completion interrupt without completion");
    a_tc_pin_cause: assert property ((~terminal_count_n_out & ~$past(xact_done_in[1:0])) == 2'h0)
        else $error("terminal count without completion");
    a_tc_one_cycle: assert property (
        !terminal_count_n_out[0] && !xact_done_in[0] |=> terminal_count_n_out[0])
        else $error("terminal count longer than one cycle");
    a_err_irq_cause: assert property (
        (descr_error_irq_out & ~$past(descr_fetch_in & ~link_valid_flag_in)) == 4'h0)
        else $error("descriptor error interrupt without invalid descriptor");
    a_halt_cause: assert property (
        (chan_halt_out & ~$past(chan_halt_out) & ~$past(descr_fetch_in & ~link_valid_flag_in)) == 4'h0)
        else $error("channel halted without invalid descriptor");
    a_ack_pin_only: assert property ((~xfer_ack_n_out & ~$past(pin_trig_sel_in[1:0])) == 2'h0)
        else $error("acknowledge pin driven for a non-pin trigger");
endmodule // dqc_dma_req_ack_props

bind dqc_dma_req_ack dqc_dma_req_ack_props u_props (.mclk_in(mclk_in), .rstn_in(rstn_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_waitrequest_out(avs_waitrequest_out), .xfer_ack_n_out(xfer_ack_n_out),
    .terminal_count_n_out(terminal_count_n_out), .realtime_ack_n_out(realtime_ack_n_out),
    .pin_trig_sel_in(pin_trig_sel_in), .xact_done_in(xact_done_in), .descr_fetch_in(descr_fetch_in),
    .link_valid_flag_in(link_valid_flag_in), .chan_halt_out(chan_halt_out), .xfer_done_irq_out(xfer_done_irq_out),
    .descr_error_irq_out(descr_error_irq_out));

`default_nettype wire

// ===== bench/dqc_requester.sv
`timescale 1ns/1ps
`default_nettype none

module dqc_requester (
    // Clock and reset.
    input wire logic mclk_in,
    input wire logic rstn_in,
    // Stimulus and pins.
    input wire logic start_in,
    input wire logic ack_n_in,
    output logic req_n_out
);
    // Requests until the acknowledge pin answers, as a level-mode device expects.
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            req_n_out <= 1'b1;
        end else if (start_in) begin
            req_n_out <= 1'b0;
        end else if (!ack_n_in) begin
            req_n_out <= 1'b1;
        end
    end
endmodule // dqc_requester

`default_nettype wire

// ===== bench/dqc_dma_req_ack_tb.sv
`timescale 1ns/1ps
`default_nettype none

module dqc_dma_req_ack_tb;
    import dqc_pkg::*;
    logic mclk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [7:0] avs_address_in = 8'h00;
    logic avs_read_in = 1'b0;
    logic avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0;
    logic [31:0] avs_readdata_out;
    logic avs_waitrequest_out;
    logic [1:0] xfer_request_n_in;
    logic [1:0] xfer_ack_n_out;
    logic [1:0] terminal_count_n_out;
    logic realtime_ack_n_out;
    logic [3:0] periph_req_in = 4'h0;
    logic [3:0] pin_trig_sel_in = 4'h1;
    logic [3:0] bus_cycle_in = 4'h0;
    logic [3:0] xact_done_in = 4'h0;
    logic [3:0] descr_fetch_in = 4'h0;
    logic [3:0] link_valid_flag_in = 4'h0;
    logic [3:0] xfer_req_out, req_from_dest_out, next_set_pick_out, chan_halt_out;
    logic [3:0] xfer_done_irq_out, descr_error_irq_out;
    logic irq_out;
    logic [1:0] start = 2'b00;
    int n_mismatch = 0;
    int num_checks = 0;
    int cyc = 0;
    int cnt;

    dqc_dma_req_ack dut (.mclk_in(mclk_in), .rstn_in(rstn_in), .avs_address_in(avs_address_in),
        .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
        .avs_byteenable_in(4'hF), .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
        .xfer_request_n_in(xfer_request_n_in), .xfer_ack_n_out(xfer_ack_n_out),
        .terminal_count_n_out(terminal_count_n_out), .realtime_ack_n_out(realtime_ack_n_out),
        .periph_req_in(periph_req_in), .pin_trig_sel_in(pin_trig_sel_in), .bus_cycle_in(bus_cycle_in),
        .xact_done_in(xact_done_in), .descr_fetch_in(descr_fetch_in), .link_valid_flag_in(link_valid_flag_in),
        .xfer_req_out(xfer_req_out), .req_from_dest_out(req_from_dest_out), .next_set_pick_out(next_set_pick_out),
        .chan_halt_out(chan_halt_out), .xfer_done_irq_out(xfer_done_irq_out),
        .descr_error_irq_out(descr_error_irq_out), .irq_out(irq_out));
    dqc_requester u_req0 (.mclk_in(mclk_in), .rstn_in(rstn_in), .start_in(start[0]), .ack_n_in(xfer_ack_n_out[0]),
        .req_n_out(xfer_request_n_in[0]));
    dqc_requester u_req1 (.mclk_in(mclk_in), .rstn_in(rstn_in), .start_in(start[1]), .ack_n_in(xfer_ack_n_out[1]),
        .req_n_out(xfer_request_n_in[1]));

    always #4 mclk_in = ~mclk_in;

    always @(posedge mclk_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One Avalon access, held until waitrequest is seen low at an edge.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        logic wt;
        @(posedge mclk_in);
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_write_in <= w;
        avs_read_in <= ~w;
        do begin
            @(posedge mclk_in);
            wt = avs_waitrequest_out;
            q = avs_readdata_out;
        end while (wt !== 1'b0);
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask

    // Pulses completion or descriptor fetch for one cycle; returns in the answering cycle.
    task automatic fire(input logic [1:0] k, input logic [3:0] m, input logic [3:0] vld);
        @(posedge mclk_in);
        xact_done_in <= k[0] ? m : 4'h0;
        descr_fetch_in <= k[1] ? m : 4'h0;
        link_valid_flag_in <= vld;
        @(posedge mclk_in);
        xact_done_in <= 4'h0;
        descr_fetch_in <= 4'h0;
        @(negedge mclk_in);
    endtask

    // Drives bus cycle of channel 0 (sel 0) or request of channel 2 for len cycles, counting active outputs.
    task automatic drive(input int sel, input int len, output int c);
        c = 0;
        for (int i = 0; i <= 16; i++) begin
            if (i > 0) begin
                @(negedge mclk_in);
                c += (sel == 0) ? int'(xfer_ack_n_out[0] === 1'b0) : int'(xfer_req_out[2] === 1'b1);
            end
            @(posedge mclk_in);
            if (sel == 0) bus_cycle_in[0] <= (i < len);
            else periph_req_in[2] <= (i < len);
        end
    endtask

    task automatic ackrun(input logic [31:0] cfg, input logic trig, input int exp);
        int c;
        wr(CFG_BASE, cfg);
        pin_trig_sel_in[0] <= trig;
        drive(0, 3, c);
        chk(c, exp);
        pin_trig_sel_in[0] <= 1'b1;
    endtask

    task automatic reqrun(input logic [31:0] cfg, input int lo, input int hi);
        int c;
        wr(CFG_BASE + 8'h08, cfg);
        drive(1, 8, c);
        chk(c >= lo && c <= hi, 1);
    endtask

    initial begin
        repeat (10) @(posedge mclk_in);
        rstn_in <= 1'b1;
        for (int n = 0; n < 4; n++) rd(CFG_BASE + 8'(4 * n), CFG_RESET);
        rd(IRQ_EN_OFS, 32'h0);
        wr(8'h3C, 32'hFFFF_FFFF);
        rd(8'h3C, 32'h0);
        chk(realtime_ack_n_out, 1);
        ackrun(32'h0000_0000, 1'b1, 1);
        ackrun(32'h0000_0200, 1'b1, 3);
        ackrun(32'h0000_0300, 1'b1, 3);
        ackrun(32'h0000_0400, 1'b1, 0);
        ackrun(32'h0000_0700, 1'b1, 0);
        ackrun(32'h0000_0200, 1'b0, 0);
        wr(CFG_BASE, 32'h0000_0120);
        @(posedge mclk_in);
        start[0] <= 1'b1;
        @(posedge mclk_in);
        start[0] <= 1'b0;
        repeat (8) @(posedge mclk_in);
        drive(0, 3, cnt);
        chk(cnt > 1 && xfer_ack_n_out[0] === 1'b1, 1);
        reqrun(32'h0000_0020, 1, 1);
        reqrun(32'h0000_0010, 1, 1);
        reqrun(32'h0000_0060, 6, 9);
        reqrun(32'h0000_0050, 7, 9);
        wr(CFG_BASE + 8'h08, 32'h0040_0008);
        repeat (3) @(posedge mclk_in);
        chk(req_from_dest_out[2], 1);
        wr(CFG_BASE, 32'h0000_0000);
        wr(IRQ_EN_OFS, 32'h1);
        fire(2'b01, 4'h1, 4'h0);
        chk(xfer_done_irq_out, 4'h1);
        chk(terminal_count_n_out, 2'b10);
        repeat (3) @(negedge mclk_in);
        chk(irq_out, 1);
        rd(IRQ_STAT_OFS, 32'h1);
        wr(IRQ_STAT_OFS, 32'h1);
        rd(IRQ_STAT_OFS, 32'h0);
        chk(irq_out, 0);
        wr(CFG_BASE, 32'h0300_0000);
        fire(2'b01, 4'h1, 4'h0);
        chk({xfer_done_irq_out, terminal_count_n_out}, 6'h03);
        wr(CFG_BASE + 8'h04, 32'h0040_0000);
        wr(IRQ_EN_OFS, 32'h0);
        fire(2'b01, 4'h2, 4'h0);
        repeat (3) @(negedge mclk_in);
        chk({irq_out, next_set_pick_out[1]}, 2'b01);
        rd(IRQ_STAT_OFS, 32'h2);
        wr(IRQ_STAT_OFS, 32'h2);
        rd(CFG_BASE + 8'h04, 32'h0040_0000);
        wr(CFG_BASE + 8'h04, 32'h2000_0000);
        fire(2'b01, 4'h2, 4'h0);
        chk(next_set_pick_out[1], 1);
        wr(CFG_BASE + 8'h04, 32'h0);
        fire(2'b10, 4'h2, 4'h2);
        chk(chan_halt_out, 4'h0);
        fire(2'b10, 4'h2, 4'h0);
        chk({descr_error_irq_out, chan_halt_out}, 8'h22);
        repeat (2) @(negedge mclk_in);
        rd(STATE_BASE + 8'h04, 32'h1);
        wr(CTRL_BASE + 8'h04, 32'h1);
        repeat (2) @(negedge mclk_in);
        chk(chan_halt_out, 4'h0);
        rd(STATE_BASE + 8'h04, 32'h0);
        wr(CFG_BASE + 8'h04, 32'h0400_0000);
        fire(2'b10, 4'h2, 4'h0);
        chk({descr_error_irq_out, chan_halt_out}, 8'h02);
        report_and_stop();
    end
endmodule // dqc_dma_req_ack_tb

`default_nettype wire
